//--- crb_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "crb_consts.svh"

// Operation
// - Decode the control-page register map from offset 01h up to 78h.
// - Writing one to full_core_reset resets the whole core and every register.
// - A full core reset also clears the processor coefficient memory.
// - full_core_reset is write-only and returns to zero by itself.
// - Writing one to the register-reset bit restores every register; self-clearing.
// - A register-only reset leaves coefficient memory untouched.
// - Every register takes its reset value after any reset; reset command resets to zero.
// - Offset 00h selects the page; the register map lives on page zero.
module crb_bank #(
    parameter int CORE_RESET_CYCLES = `CRB_CORE_RESET_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    // Byte access from the control-port engine
    input  wire crb_pkg::crb_req_s             cp_req,
    output var  logic [7:0]                    rd_data_q,
    output var  logic                          rd_ack_q,
    // Live status from the core
    input  wire crb_pkg::crb_status_s          status,
    // Register contents driving the core
    output var  logic [crb_pkg::RW_SLOTS-1:0][7:0] cfg_q,
    output var  logic [7:0]                    page_q,
    output var  logic [7:0]                    book_q,
    // Reset and clear commands to the core
    output var  logic                          core_reset_q,
    output var  logic                          coef_clear_q,
    output var  logic                          fault_ack_q,
    output var  logic [7:0]                    fault_ack_data_q
);

    localparam logic [7:0] CORE_CNT_INIT = 8'(CORE_RESET_CYCLES);

    // Map a page-zero offset to its kind and slot
    function automatic crb_pkg::crb_dec_s decode(input logic [7:0] ofs);
        crb_pkg::crb_dec_s d;
        d.loc  = crb_pkg::CRB_LOC_RW;
        d.slot = 5'h00;
        case (ofs)
            `CRB_OFS_DEVICE_CONTROL_ONE:   d.slot = 5'h00;
            `CRB_OFS_DEVICE_CONTROL_TWO:   d.slot = 5'h01;
            `CRB_OFS_PAGE_INCREMENT_CTRL:  d.slot = 5'h02;
            `CRB_OFS_SAMPLE_RATE_CONFIG:   d.slot = 5'h03;
            `CRB_OFS_CLOCK_CHECK_CONTROL:  d.slot = 5'h04;
            `CRB_OFS_SERIAL_OUT_SELECT:    d.slot = 5'h05;
            `CRB_OFS_AUDIO_PORT_CONTROL:   d.slot = 5'h06;
            `CRB_OFS_AUDIO_PORT_CONFIG_1:  d.slot = 5'h07;
            `CRB_OFS_AUDIO_PORT_CONFIG_2:  d.slot = 5'h08;
            `CRB_OFS_AUDIO_PORT_CONFIG_3:  d.slot = 5'h09;
            `CRB_OFS_VOLUME_LEVEL:         d.slot = 5'h0a;
            `CRB_OFS_VOLUME_RAMP_ONE:      d.slot = 5'h0b;
            `CRB_OFS_VOLUME_RAMP_TWO:      d.slot = 5'h0c;
            `CRB_OFS_SILENCE_MUTE_CONTROL: d.slot = 5'h0d;
            `CRB_OFS_SILENCE_MUTE_DELAY:   d.slot = 5'h0e;
            `CRB_OFS_OUTPUT_STAGE_CONTROL: d.slot = 5'h0f;
            `CRB_OFS_OUTPUT_GAIN:          d.slot = 5'h10;
            `CRB_OFS_FILTER_WRITE_CONTROL: d.slot = 5'h11;
            `CRB_OFS_CONVERTER_CONTROL:    d.slot = 5'h12;
            `CRB_OFS_ADDRESS_PIN_CONTROL:  d.slot = 5'h13;
            `CRB_OFS_ADDRESS_PIN_FUNCTION: d.slot = 5'h14;
            `CRB_OFS_PROCESSOR_MISC:       d.slot = 5'h15;
            `CRB_OFS_SWITCHING_PHASE_CTRL: d.slot = 5'h16;
            `CRB_OFS_PIN_BEHAVIOUR_ONE:    d.slot = 5'h1c;
            `CRB_OFS_PIN_BEHAVIOUR_TWO:    d.slot = 5'h1d;
            `CRB_OFS_MISC_SETTINGS:        d.slot = 5'h1e;
            `CRB_OFS_FRAME_RATE_MONITOR,
            `CRB_OFS_BIT_CLOCK_MONITOR,
            `CRB_OFS_CLOCK_CHECK_RESULT,
            `CRB_OFS_SILICON_IDENTITY,
            `CRB_OFS_OPERATING_STATE,
            `CRB_OFS_SILENCE_MUTE_STATE,
            `CRB_OFS_CHANNEL_FAULT_STATUS,
            `CRB_OFS_DEVICE_FAULT_ONE,
            `CRB_OFS_DEVICE_FAULT_TWO,
            `CRB_OFS_THERMAL_WARNING:      d.loc = crb_pkg::CRB_LOC_RO;
            `CRB_OFS_RESET_COMMAND:        d.loc = crb_pkg::CRB_LOC_RESET;
            `CRB_OFS_FAULT_ACKNOWLEDGE:    d.loc = crb_pkg::CRB_LOC_FAULT;
            default: begin
                // Spread spectrum block is contiguous, 6Bh to 6Fh
                if (ofs >= `CRB_OFS_SPREAD_SPECTRUM_ZERO && ofs <= `CRB_OFS_SPREAD_SPECTRUM_FOUR) begin
                    d.slot = 5'(ofs - `CRB_OFS_SPREAD_SPECTRUM_ZERO) + 5'h17;
                end else begin
                    d.loc = crb_pkg::CRB_LOC_NONE;
                end
            end
        endcase
        return d;
    endfunction

    // Reset value of one writable slot
    function automatic logic [7:0] reset_value(input int slot);
        logic [7:0] v;
        v = `CRB_RV_DEFAULT;
        if (slot == int'(`CRB_SLOT_DEVICE_CONTROL_TWO)) begin
            v = `CRB_RV_DEVICE_CONTROL_TWO;
        end
        return v;
    endfunction

    // Pick the live status byte for a read-only offset
    function automatic logic [7:0] status_byte(input logic [7:0] ofs, input crb_pkg::crb_status_s s);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            `CRB_OFS_FRAME_RATE_MONITOR:   v = s.frame_rate_monitor;
            `CRB_OFS_BIT_CLOCK_MONITOR:    v = s.bit_clock_monitor;
            `CRB_OFS_CLOCK_CHECK_RESULT:   v = s.clock_check_result;
            `CRB_OFS_SILICON_IDENTITY:     v = s.silicon_identity;
            `CRB_OFS_OPERATING_STATE:      v = s.operating_state;
            `CRB_OFS_SILENCE_MUTE_STATE:   v = s.silence_mute_state;
            `CRB_OFS_CHANNEL_FAULT_STATUS: v = s.channel_fault_status;
            `CRB_OFS_DEVICE_FAULT_ONE:     v = s.device_fault_one;
            `CRB_OFS_DEVICE_FAULT_TWO:     v = s.device_fault_two;
            `CRB_OFS_THERMAL_WARNING:      v = s.thermal_warning;
            default:                       v = 8'h00;
        endcase
        return v;
    endfunction

    // Decoded access and command strobes
    logic              on_map;
    logic              is_page_sel;
    logic              is_book_sel;
    crb_pkg::crb_dec_s dec;
    logic              wr_ok;
    logic              rd_ok;
    logic              wr_reset_cmd;
    logic              start_core_reset;
    logic              start_reg_reset;
    logic              clear_regs;
    logic [7:0]        core_cnt_q;
    logic [7:0]        core_cnt_d;

    // Access decode; nothing is taken while the core reset runs
    always_comb begin
        on_map       = (page_q == `CRB_CONTROL_PAGE) && (book_q == `CRB_CONTROL_BOOK);
        is_page_sel  = (cp_req.addr == `CRB_OFS_PAGE_SELECT);
        is_book_sel  = (page_q == `CRB_CONTROL_PAGE) && (cp_req.addr == `CRB_OFS_BOOK_SELECT);
        dec          = decode(cp_req.addr);
        wr_ok        = cp_req.wr && !core_reset_q;
        rd_ok        = cp_req.rd && !cp_req.wr && !core_reset_q;
        wr_reset_cmd = wr_ok && on_map && (dec.loc == crb_pkg::CRB_LOC_RESET);
        start_core_reset = wr_reset_cmd && cp_req.data[`CRB_BIT_FULL_CORE_RESET];
        start_reg_reset  = wr_reset_cmd && cp_req.data[`CRB_BIT_REGISTER_RESET];
        clear_regs       = start_core_reset || start_reg_reset || core_reset_q;
    end

    // Full core reset length counter
    always_comb begin
        core_cnt_d = core_cnt_q;
        if (start_core_reset) begin
            core_cnt_d = CORE_CNT_INIT;
        end else if (core_cnt_q != 8'h00) begin
            core_cnt_d = core_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            core_cnt_q <= 8'h00;
        end else begin
            core_cnt_q <= core_cnt_d;
        end
    end

    // Core reset and coefficient clear run together for the whole count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            core_reset_q <= 1'b0;
            coef_clear_q <= 1'b0;
        end else begin
            core_reset_q <= (core_cnt_d != 8'h00);
            coef_clear_q <= (core_cnt_d != 8'h00);
        end
    end

    // Writable register slots
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < crb_pkg::RW_SLOTS; i++) begin
                cfg_q[i] <= reset_value(i);
            end
        end else if (clear_regs) begin
            for (int i = 0; i < crb_pkg::RW_SLOTS; i++) begin
                cfg_q[i] <= reset_value(i);
            end
        end else if (wr_ok && on_map && dec.loc == crb_pkg::CRB_LOC_RW) begin
            cfg_q[dec.slot] <= cp_req.data;
        end
    end

    // Page and book selectors
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            page_q <= 8'h00;
            book_q <= 8'h00;
        end else if (clear_regs) begin
            page_q <= 8'h00;
            book_q <= 8'h00;
        end else if (wr_ok && is_page_sel) begin
            page_q <= cp_req.data;
        end else if (wr_ok && is_book_sel) begin
            book_q <= cp_req.data;
        end
    end

    // Fault acknowledge strobe with the written byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            fault_ack_q      <= 1'b0;
            fault_ack_data_q <= 8'h00;
        end else begin
            fault_ack_q <= wr_ok && on_map && (dec.loc == crb_pkg::CRB_LOC_FAULT);
            if (wr_ok && on_map && dec.loc == crb_pkg::CRB_LOC_FAULT) begin
                fault_ack_data_q <= cp_req.data;
            end
        end
    end

    // Read data, answered one cycle after the request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= 8'h00;
            rd_ack_q  <= 1'b0;
        end else begin
            rd_ack_q <= rd_ok;
            if (rd_ok) begin
                if (is_page_sel) begin
                    rd_data_q <= page_q;
                end else if (is_book_sel) begin
                    rd_data_q <= book_q;
                end else if (!on_map) begin
                    rd_data_q <= 8'h00;
                end else begin
                    case (dec.loc)
                        crb_pkg::CRB_LOC_RW:    rd_data_q <= cfg_q[dec.slot];
                        crb_pkg::CRB_LOC_RO:    rd_data_q <= status_byte(cp_req.addr, status);
                        crb_pkg::CRB_LOC_RESET: rd_data_q <= `CRB_RV_RESET_COMMAND;
                        crb_pkg::CRB_LOC_FAULT: rd_data_q <= 8'h00;
                        default:                rd_data_q <= 8'h00;
                    endcase
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- crb_consts.svh
`ifndef CRB_CONSTS_SVH
`define CRB_CONSTS_SVH

// Paging registers
`define CRB_OFS_PAGE_SELECT           8'h00
`define CRB_OFS_BOOK_SELECT           8'h7f
`define CRB_CONTROL_PAGE              8'h00
`define CRB_CONTROL_BOOK              8'h00

// Reset command register and its fields
`define CRB_OFS_RESET_COMMAND         8'h01
`define CRB_BIT_FULL_CORE_RESET       4
`define CRB_BIT_REGISTER_RESET        0

// Writable registers, in slot order 0..30
`define CRB_OFS_DEVICE_CONTROL_ONE    8'h02
`define CRB_OFS_DEVICE_CONTROL_TWO    8'h03
`define CRB_OFS_PAGE_INCREMENT_CTRL   8'h0f
`define CRB_OFS_SAMPLE_RATE_CONFIG    8'h28
`define CRB_OFS_CLOCK_CHECK_CONTROL   8'h29
`define CRB_OFS_SERIAL_OUT_SELECT     8'h30
`define CRB_OFS_AUDIO_PORT_CONTROL    8'h31
`define CRB_OFS_AUDIO_PORT_CONFIG_1   8'h33
`define CRB_OFS_AUDIO_PORT_CONFIG_2   8'h34
`define CRB_OFS_AUDIO_PORT_CONFIG_3   8'h35
`define CRB_OFS_VOLUME_LEVEL          8'h4c
`define CRB_OFS_VOLUME_RAMP_ONE       8'h4e
`define CRB_OFS_VOLUME_RAMP_TWO       8'h4f
`define CRB_OFS_SILENCE_MUTE_CONTROL  8'h50
`define CRB_OFS_SILENCE_MUTE_DELAY    8'h51
`define CRB_OFS_OUTPUT_STAGE_CONTROL  8'h53
`define CRB_OFS_OUTPUT_GAIN           8'h54
`define CRB_OFS_FILTER_WRITE_CONTROL  8'h5c
`define CRB_OFS_CONVERTER_CONTROL     8'h5d
`define CRB_OFS_ADDRESS_PIN_CONTROL   8'h60
`define CRB_OFS_ADDRESS_PIN_FUNCTION  8'h61
`define CRB_OFS_PROCESSOR_MISC        8'h66
`define CRB_OFS_SWITCHING_PHASE_CTRL  8'h6a
`define CRB_OFS_SPREAD_SPECTRUM_ZERO  8'h6b
`define CRB_OFS_SPREAD_SPECTRUM_FOUR  8'h6f
`define CRB_OFS_PIN_BEHAVIOUR_ONE     8'h74
`define CRB_OFS_PIN_BEHAVIOUR_TWO     8'h75
`define CRB_OFS_MISC_SETTINGS         8'h76

// Read-only status registers
`define CRB_OFS_FRAME_RATE_MONITOR    8'h37
`define CRB_OFS_BIT_CLOCK_MONITOR     8'h38
`define CRB_OFS_CLOCK_CHECK_RESULT    8'h39
`define CRB_OFS_SILICON_IDENTITY      8'h67
`define CRB_OFS_OPERATING_STATE       8'h68
`define CRB_OFS_SILENCE_MUTE_STATE    8'h69
`define CRB_OFS_CHANNEL_FAULT_STATUS  8'h70
`define CRB_OFS_DEVICE_FAULT_ONE      8'h71
`define CRB_OFS_DEVICE_FAULT_TWO      8'h72
`define CRB_OFS_THERMAL_WARNING       8'h73

// Fault acknowledge, a write strobe that reads as zero
`define CRB_OFS_FAULT_ACKNOWLEDGE     8'h78

// Reset values
`define CRB_RV_DEFAULT                8'h00
`define CRB_RV_DEVICE_CONTROL_TWO     8'h10
`define CRB_RV_RESET_COMMAND          8'h00
`define CRB_SLOT_DEVICE_CONTROL_TWO   5'h01

// Length of the full core reset pulse, in clk_sys cycles
`define CRB_CORE_RESET_CYCLES         16

`endif

//--- crb_pkg.sv
`default_nettype none

package crb_pkg;

    // Number of writable register slots
    localparam int RW_SLOTS = 31;

    // Byte access from the control-port engine, same clock
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } crb_req_s;

    // Live status bytes presented by the core for read-only registers
    typedef struct packed {
        logic [7:0] frame_rate_monitor;
        logic [7:0] bit_clock_monitor;
        logic [7:0] clock_check_result;
        logic [7:0] silicon_identity;
        logic [7:0] operating_state;
        logic [7:0] silence_mute_state;
        logic [7:0] channel_fault_status;
        logic [7:0] device_fault_one;
        logic [7:0] device_fault_two;
        logic [7:0] thermal_warning;
    } crb_status_s;

    // Kind of location an offset decodes to
    typedef enum logic [2:0] {
        CRB_LOC_NONE   = 3'b000,
        CRB_LOC_RW     = 3'b001,
        CRB_LOC_RO     = 3'b010,
        CRB_LOC_RESET  = 3'b011,
        CRB_LOC_FAULT  = 3'b100
    } crb_loc_e;

    // Result of decoding one offset
    typedef struct packed {
        crb_loc_e   loc;
        logic [4:0] slot;
    } crb_dec_s;

endpackage

`default_nettype wire

//--- crb_bank_sva.sv
`timescale 1ns/10ps
`default_nettype none
module crb_bank_sva #(
    parameter int CORE_RESET_CYCLES = 16
) (
    // Clock and reset
    input wire logic                              clk_sys,
    input wire logic                              reset_n,
    // Register port
    input wire crb_pkg::crb_req_s                 cp_req,
    input wire logic [7:0]                        rd_data_q,
    input wire logic                              rd_ack_q,
    // Register contents and commands
    input wire logic [crb_pkg::RW_SLOTS-1:0][7:0] cfg_q,
    input wire logic [7:0]                        page_q,
    input wire logic [7:0]                        book_q,
    input wire logic                              core_reset_q,
    input wire logic                              coef_clear_q,
    input wire logic                              fault_ack_q,
    input wire logic [7:0]                        fault_ack_data_q
);
    logic [7:0] run_q;
    wire        tk = !core_reset_q;
    wire        p0 = page_q == 8'h00 && book_q == 8'h00;
    wire        rq = cp_req.rd && !cp_req.wr && tk;
    wire        wq = cp_req.wr && tk && p0;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Counts consecutive cycles of core reset
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 8'h00;
        end else begin
            run_q <= core_reset_q ? run_q + 8'h01 : 8'h00;
        end
    end
    read_ack_a: assert property (rq |=> rd_ack_q)
        else $error("read not answered");
    no_ack_a: assert property (!rq |=> !rd_ack_q)
        else $error("answer without a taken read");
    cmd_reads_zero_a: assert property (rq && cp_req.addr inside {8'h01, 8'h78} |=> rd_data_q == 8'h00)
        else $error("command register read not zero");
    core_start_a: assert property (wq && cp_req.addr == 8'h01 && cp_req.data[4]
        |=> core_reset_q && cfg_q[1] == 8'h10 && cfg_q[0] == 8'h00 && page_q == 8'h00)
        else $error("full core reset not started");
    core_length_a: assert property ($fell(core_reset_q) |-> run_q == CORE_RESET_CYCLES)
        else $error("core reset length wrong");
    coef_tie_a: assert property (coef_clear_q == core_reset_q)
        else $error("coefficient clear not tied to core reset");
    reg_reset_a: assert property (wq && cp_req.addr == 8'h01 && !cp_req.data[4] && cp_req.data[0]
        |=> !core_reset_q && cfg_q[1] == 8'h10 && cfg_q[30] == 8'h00 && p0)
        else $error("register reset wrong");
    page_sel_a: assert property (cp_req.wr && tk && cp_req.addr == 8'h00 |=> page_q == $past(cp_req.data))
        else $error("page not selected");
    far_page_a: assert property (rq && page_q != 8'h00 && cp_req.addr != 8'h00 |=> rd_data_q == 8'h00)
        else $error("other page read not zero");
    fault_ack_a: assert property (wq && cp_req.addr == 8'h78
        |=> fault_ack_q && fault_ack_data_q == $past(cp_req.data))
        else $error("fault acknowledge missing");
    rw_store_a: assert property (wq && cp_req.addr == 8'h4c |=> cfg_q[10] == $past(cp_req.data))
        else $error("volume byte not stored");
endmodule
bind crb_bank crb_bank_sva #(.CORE_RESET_CYCLES(CORE_RESET_CYCLES)) u_sva (
    .clk_sys(clk_sys), .reset_n(reset_n), .cp_req(cp_req), .rd_data_q(rd_data_q),
    .rd_ack_q(rd_ack_q), .cfg_q(cfg_q), .page_q(page_q), .book_q(book_q),
    .core_reset_q(core_reset_q), .coef_clear_q(coef_clear_q), .fault_ack_q(fault_ack_q),
    .fault_ack_data_q(fault_ack_data_q)
);
`default_nettype wire

//--- crb_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module crb_core_model (
    // Clock and reset
    input  wire logic           clk_sys,
    input  wire logic           reset_n,
    // Commands
    input  wire logic           coef_clear_q,
    input  wire logic           coef_load,
    // Status and memory
    output var  crb_pkg::crb_status_s status,
    output var  logic [7:0]     coef_q
);
    // Status byte k reads c0h plus k; the identity byte reads c3h
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            status[79-8*k -: 8] = 8'hc0 + 8'(k);
        end
    end
    // Coefficient memory, wiped only by the core reset or by reset_n
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            coef_q <= 8'h00;
        end else if (coef_clear_q) begin
            coef_q <= 8'h00;
        end else if (coef_load) begin
            coef_q <= 8'h3c;
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int CRC = 3;
    localparam logic [7:0] RW_OFS [31] = '{8'h02, 8'h03, 8'h0f, 8'h28, 8'h29, 8'h30, 8'h31, 8'h33,
        8'h34, 8'h35, 8'h4c, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h53, 8'h54, 8'h5c, 8'h5d, 8'h60, 8'h61,
        8'h66, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h74, 8'h75, 8'h76};
    localparam logic [7:0] RO_OFS [10] = '{8'h37, 8'h38, 8'h39, 8'h67, 8'h68, 8'h69, 8'h70, 8'h71, 8'h72, 8'h73};
    logic                              clk_sys = 1'b0;
    logic                              reset_n = 1'b0;
    logic                              coef_load = 1'b0;
    crb_pkg::crb_req_s                 cp_req = '0;
    crb_pkg::crb_status_s              status;
    logic [7:0]                        rd_data_q, page_q, book_q, fault_ack_data_q, coef_q;
    logic                              rd_ack_q, core_reset_q, coef_clear_q, fault_ack_q;
    logic [crb_pkg::RW_SLOTS-1:0][7:0] cfg_q;
    int                                n_errors = 0;
    int                                checks_done = 0;
    int                                cyc = 0;
    int                                i, n;
    crb_bank #(.CORE_RESET_CYCLES(CRC)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .cp_req(cp_req),
        .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .status(status), .cfg_q(cfg_q), .page_q(page_q),
        .book_q(book_q), .core_reset_q(core_reset_q), .coef_clear_q(coef_clear_q),
        .fault_ack_q(fault_ack_q), .fault_ack_data_q(fault_ack_data_q));
    crb_core_model u_core (.clk_sys(clk_sys), .reset_n(reset_n), .coef_clear_q(coef_clear_q),
        .coef_load(coef_load), .status(status), .coef_q(coef_q));
    // Clock and hang guard
    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end
    function automatic logic [7:0] rv(input int k);
        return (k == 1) ? 8'h10 : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One byte write, taken at the rising edge inside the call
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cp_req = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys);
        cp_req.wr = 1'b0;
    endtask
    // One byte read, answer checked in its acknowledge cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        cp_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_sys);
        cp_req.rd = 1'b0;
        chk({7'h00, rd_ack_q}, 8'h01);
        chk(rd_data_q, e);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        for (i = 0; i < 31; i++) begin
            rd(RW_OFS[i], rv(i));
        end
        rd(8'h01, 8'h00);
        rd(8'h78, 8'h00);
        for (i = 0; i < 10; i++) begin
            rd(RO_OFS[i], 8'hc0 + 8'(i));
        end
        $display("test reset values done");
        for (i = 0; i < 31; i++) begin
            wr(RW_OFS[i], RW_OFS[i] ^ 8'h5a);
            chk(cfg_q[i], RW_OFS[i] ^ 8'h5a);
            rd(RW_OFS[i], RW_OFS[i] ^ 8'h5a);
        end
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h00);
        wr(8'h37, 8'hff);
        rd(8'h37, 8'hc0);
        wr(8'h78, 8'ha5);
        chk({7'h00, fault_ack_q}, 8'h01);
        chk(fault_ack_data_q, 8'ha5);
        $display("test map done");
        wr(8'h00, 8'h05);
        chk(page_q, 8'h05);
        rd(8'h4c, 8'h00);
        wr(8'h4c, 8'h11);
        wr(8'h00, 8'h00);
        rd(8'h4c, 8'h4c ^ 8'h5a);
        wr(8'h7f, 8'h03);
        chk(book_q, 8'h03);
        rd(8'h02, 8'h00);
        wr(8'h7f, 8'h00);
        $display("test paging done");
        @(negedge clk_sys);
        coef_load = 1'b1;
        @(negedge clk_sys);
        coef_load = 1'b0;
        wr(8'h01, 8'h01);
        chk(cfg_q[0], 8'h00);
        chk(cfg_q[1], 8'h10);
        chk({7'h00, core_reset_q}, 8'h00);
        chk(coef_q, 8'h3c);
        rd(8'h01, 8'h00);
        $display("test register reset done");
        for (i = 0; i < 2; i++) begin
            // Reload the coefficient memory so that each wipe is visible
            coef_load = 1'b1;
            wr(8'h4c, 8'h77);
            coef_load = 1'b0;
            wr(8'h01, 8'h10 | 8'(i));
            chk({6'h00, core_reset_q, coef_clear_q}, 8'h03);
            chk(cfg_q[10], 8'h00);
            n = 0;
            while (core_reset_q === 1'b1 && n < 50) begin
                n++;
                cp_req.rd = (n == 2);
                if (n == 3) chk({7'h00, rd_ack_q}, 8'h00);
                @(negedge clk_sys);
            end
            chk(8'(n), 8'(CRC));
            chk(coef_q, 8'h00);
            rd(8'h01, 8'h00);
        end
        $display("test core reset done");
        wr(8'h4c, 8'h33);
        reset_n = 1'b0;
        @(negedge clk_sys);
        chk(cfg_q[10], 8'h00);
        chk(cfg_q[1], 8'h10);
        reset_n = 1'b1;
        rd(8'h4c, 8'h00);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
